/* File: design/icache_control_regs.sv */
// Instruction cache control registers and 64-entry direct-mapped array.
// Assumes the prefetch path and move unit run on clk_sys_i; the
// inhibit pin is asynchronous and is synchronised here.
`timescale 1ns/10ps
`default_nettype none
module icache_control_regs
    import icache_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Control-register move port
    input wire logic creg_wr_i,
    input wire logic creg_sel_i,
    input wire logic [31:0] creg_wdata_i,
    output logic [31:0] creg_rdata_o,
    // External inhibit, active low pin
    input wire logic cache_inhibit_input_n_i,
    // Prefetch lookup
    input wire logic fetch_req_i,
    input wire logic [31:0] fetch_addr_i,
    input wire logic supervisor_space_code_bit_i,
    output logic fetch_hit_o,
    output logic [31:0] fetch_data_o,
    // Miss refill from external memory
    input wire logic refill_valid_i,
    input wire logic [31:0] refill_addr_i,
    input wire logic refill_fc2_i,
    input wire logic [31:0] refill_data_i,
    output logic cache_active_o
);
    logic freeze_reg;
    logic enable_reg;
    logic [IDX_W-1:0] addr_idx_reg;
    logic inh_meta_reg;
    logic inh_sync_reg;
    logic hit_reg;
    logic [31:0] hit_data_reg;
    logic [31:0] rdata_reg;
    logic [ENTRIES-1:0] valid_w;
    logic [TAG_W-1:0] tag_w [ENTRIES];
    logic [31:0] data_w [ENTRIES];

    // Move decode
    wire wr_ctl = creg_wr_i && (creg_sel_i == SEL_CONTROL);
    wire wr_addr = creg_wr_i && (creg_sel_i == SEL_ENTRY_ADDRESS);
    wire clr_all = wr_ctl && creg_wdata_i[CTL_CLR_ALL_BIT]; // RL4
    wire clr_entry = wr_ctl && creg_wdata_i[CTL_CLR_ENTRY_BIT]; // RL4
    // Effective enable: inhibit pin wins over enable bit
    wire inhibited = ~inh_sync_reg;
    wire active = enable_reg && !inhibited; // RL19
    // Lookup index and tag
    wire [IDX_W-1:0] f_idx = fetch_addr_i[IDX_MSB:IDX_LSB];
    wire [TAG_W-1:0] f_tag = {supervisor_space_code_bit_i, fetch_addr_i[31:TAG_ADDR_LSB]}; // RL17
    wire [IDX_W-1:0] r_idx = refill_addr_i[IDX_MSB:IDX_LSB];
    wire [TAG_W-1:0] r_tag = {refill_fc2_i, refill_addr_i[31:TAG_ADDR_LSB]};
    wire f_match = valid_w[f_idx] && (tag_w[f_idx] == f_tag); // RL14
    wire do_fill = refill_valid_i && active && !freeze_reg; // RL9
    // Read mux; commands and reserved bits read zero
    wire [31:0] ctl_view = {28'h0000000, 1'b0, 1'b0, freeze_reg, enable_reg}; // RL2 RL6 RL8
    wire [31:0] addr_view = {24'h000000, addr_idx_reg, 2'h0}; // RL15
    wire [31:0] rdata_next = (creg_sel_i == SEL_ENTRY_ADDRESS) ? addr_view : ctl_view;

    // Inhibit pin synchroniser, idles released
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inh_meta_reg <= 1'b1;
            inh_sync_reg <= 1'b1;
        end else begin
            inh_meta_reg <= cache_inhibit_input_n_i;
            inh_sync_reg <= inh_meta_reg;
        end
    end

    // Control register mode bits
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            freeze_reg <= CTL_FREEZE_RST; // RL11
            enable_reg <= CTL_ENABLE_RST; // RL13
        end else if (wr_ctl) begin
            freeze_reg <= creg_wdata_i[CTL_FREEZE_BIT]; // RL1
            enable_reg <= creg_wdata_i[CTL_ENABLE_BIT];
        end
    end

    // Entry address register index field
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_idx_reg <= ADDR_IDX_RST;
        end else if (wr_addr) begin
            addr_idx_reg <= creg_wdata_i[IDX_MSB:IDX_LSB]; // RL16
        end
    end

    // Registered read data and lookup answer
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h00000000;
            hit_reg <= 1'b0;
            hit_data_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
            hit_reg <= fetch_req_i && active && f_match; // RL12
            hit_data_reg <= data_w[f_idx];
        end
    end

    // Entry array
    for (genvar g = 0; g < ENTRIES; g++) begin : g_entry
        icache_entry u_entry (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .fill_i(do_fill && (r_idx == IDX_W'(g))), // RL10
            .inval_i(clr_all || (clr_entry && (addr_idx_reg == IDX_W'(g)))), // RL5 RL7
            .tag_i(r_tag),
            .data_i(refill_data_i),
            .valid_o(valid_w[g]),
            .tag_o(tag_w[g]),
            .data_o(data_w[g])
        );
    end

    assign creg_rdata_o = rdata_reg;
    assign fetch_hit_o = hit_reg;
    assign fetch_data_o = hit_data_reg;
    assign cache_active_o = active;

    // Control read: reserved and command bits zero
    a_ctl_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL2 RL6 RL8
        !$past(creg_sel_i) |-> creg_rdata_o[31:2] == 30'h0)
        else $error("control read reserved or command bit set");

    // Control read returns the mode bits
    a_ctl_read_modes: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL1
        !$past(creg_sel_i) |-> creg_rdata_o[1:0] == {$past(freeze_reg), $past(enable_reg)})
        else $error("control read lost a mode bit");

    // Control write lands in the mode bits
    a_ctl_write_modes: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL4
        wr_ctl |=> {freeze_reg, enable_reg} == $past({creg_wdata_i[CTL_FREEZE_BIT], creg_wdata_i[CTL_ENABLE_BIT]}))
        else $error("control write missed a mode bit");

    // Address read: reserved bits zero
    a_addr_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL15
        $past(creg_sel_i) |-> (creg_rdata_o[31:8] == 24'h0 && creg_rdata_o[1:0] == 2'h0))
        else $error("address read reserved bits set");

    // Address read returns the held index
    a_addr_read_index: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL16
        $past(creg_sel_i) |-> creg_rdata_o[7:2] == $past(addr_idx_reg))
        else $error("address read lost the index");

    // Address write keeps only the index field
    a_addr_write_index: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL16
        wr_addr |=> addr_idx_reg == $past(creg_wdata_i[IDX_MSB:IDX_LSB]))
        else $error("address write missed the index");

    // Reset leaves modes off
    a_reset_modes_off: assert property (@(posedge clk_sys_i) // RL11 RL13
        $rose(rst_n_i) |-> (!freeze_reg && !enable_reg))
        else $error("mode bit set after reset");

    // Reset leaves no valid entry
    a_reset_all_invalid: assert property (@(posedge clk_sys_i) // RL18
        $rose(rst_n_i) |-> valid_w == '0)
        else $error("valid entry after reset");

    // Clear-all empties the array
    a_clear_all_flush: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL5
        clr_all |=> valid_w == '0)
        else $error("clear all left a valid entry");

    // Clear-entry drops the indexed entry
    a_clear_entry_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL7
        clr_entry |=> !valid_w[$past(addr_idx_reg)])
        else $error("clear entry left entry valid");

    // Clear-entry spares every other entry
    a_clear_entry_spares: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL7
        (clr_entry && !clr_all && !do_fill) |=> (valid_w | (ENTRIES'(1) << $past(addr_idx_reg))) ==
            ($past(valid_w) | (ENTRIES'(1) << $past(addr_idx_reg))))
        else $error("clear entry touched another entry");

    // Frozen cache gains no valid entry
    a_freeze_no_fill: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL9
        freeze_reg |=> (valid_w & ~$past(valid_w)) == '0)
        else $error("frozen cache gained an entry");

    // Frozen refill leaves the tag alone
    a_freeze_keeps_tag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL9
        (refill_valid_i && freeze_reg) |=> tag_w[$past(r_idx)] == $past(tag_w[r_idx]))
        else $error("frozen refill changed a tag");

    // Refill sets the valid bit
    a_fill_sets_valid: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL10
        (do_fill && !clr_all && !clr_entry) |=> valid_w[$past(r_idx)])
        else $error("refill did not set valid");

    // Refill writes tag and data
    a_fill_writes_tag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL10
        (do_fill && !clr_all && !clr_entry) |=>
            (tag_w[$past(r_idx)] == $past(r_tag) && data_w[$past(r_idx)] == $past(refill_data_i)))
        else $error("refill lost tag or data");

    // No hit while inactive
    a_no_hit_disabled: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL12
        !active |=> !fetch_hit_o)
        else $error("hit while disabled");

    // Inactive cache gains no valid entry
    a_inactive_no_fill: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL12
        !active |=> (valid_w & ~$past(valid_w)) == '0)
        else $error("inactive cache gained an entry");

    // Hit only on a requested tag match
    a_hit_needs_match: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL17
        fetch_hit_o |-> $past(fetch_req_i && f_match))
        else $error("hit without a tag match");

    // Hit returns the indexed entry's data
    a_hit_data_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL17
        fetch_hit_o |-> fetch_data_o == $past(data_w[f_idx]))
        else $error("hit data not from entry");

    // Held inhibit pin forces the cache off
    a_inhibit_forces_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL19
        !cache_inhibit_input_n_i [*3] |-> !cache_active_o)
        else $error("active while inhibited");

    // Mode writes keep valid bits
    a_disable_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL14
        (wr_ctl && !clr_all && !clr_entry && !do_fill) |=> valid_w == $past(valid_w))
        else $error("mode write changed valid bits");
endmodule
`default_nettype wire

/* File: design/icache_pkg.sv */
// Constants for the instruction cache control block.
// Assumes one processor clock and an active low asynchronous reset.
// What this block does
// RL1: 32-bit control register, move-readable, reset-modified
// RL2: Control bits 31..4 read zero, ignored
// RL3: Software keeps reserved control bits zero
// RL4: Bit3 clear-all, bit2 clear-entry, bit1 freeze, bit0 enable
// RL5: Clear-all write invalidates every entry
// RL6: Clear-all bit always reads zero
// RL7: Clear-entry invalidates indexed entry, regardless of modes
// RL8: Clear-entry bit always reads zero
// RL9: Freeze blocks miss refill of entry
// RL10: Unfrozen miss refills data, tag, valid
// RL11: Reset clears freeze bit
// RL12: Hits only while enabled, else bypass
// RL13: Reset clears enable bit
// RL14: Disabling keeps entries valid
// RL15: 32-bit entry address register, reserved bits
// RL16: Index field holds address bits 7..2
// RL17: 64 direct-mapped long-word entries with tags
// RL18: Reset clears all valid bits
// RL19: Inhibit input forces cache disabled
package icache_pkg;
    localparam int ENTRIES = 64;
    localparam int IDX_W = 6;
    localparam int TAG_W = 25;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 7;
    localparam int TAG_ADDR_LSB = 8;
    localparam int CTL_CLR_ALL_BIT = 3;
    localparam int CTL_CLR_ENTRY_BIT = 2;
    localparam int CTL_FREEZE_BIT = 1;
    localparam int CTL_ENABLE_BIT = 0;
    localparam logic CTL_FREEZE_RST = 1'h0;
    localparam logic CTL_ENABLE_RST = 1'h0;
    localparam logic [IDX_W-1:0] ADDR_IDX_RST = 6'h00;
    typedef enum logic [0:0] {
        SEL_CONTROL = 1'b0,
        SEL_ENTRY_ADDRESS = 1'b1
    } creg_sel_t;
endpackage

/* File: design/icache_entry.sv */
// One cache entry: valid bit, tag and long word of data.
// Assumes the top decodes which entry is written or invalidated.
`timescale 1ns/10ps
`default_nettype none
module icache_entry
    import icache_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic fill_i,
    input wire logic inval_i,
    input wire logic [TAG_W-1:0] tag_i,
    input wire logic [31:0] data_i,
    output logic valid_o,
    output logic [TAG_W-1:0] tag_o,
    output logic [31:0] data_o
);
    logic valid_reg;
    logic [TAG_W-1:0] tag_reg;
    logic [31:0] data_reg;

    // Invalidate beats fill in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_reg <= 1'b0; // RL18
        end else if (inval_i) begin
            valid_reg <= 1'b0; // RL5
        end else if (fill_i) begin
            valid_reg <= 1'b1; // RL10
        end
    end

    // Tag and data follow the fill strobe only
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tag_reg <= '0;
            data_reg <= 32'h00000000;
        end else if (fill_i) begin
            tag_reg <= tag_i; // RL10
            data_reg <= data_i;
        end
    end

    assign valid_o = valid_reg;
    assign tag_o = tag_reg;
    assign data_o = data_reg;
endmodule
`default_nettype wire

/* File: tb/prefetch_mem.sv */
// Prefetch memory model: answers each lookup miss with a one-cycle refill.
// Assumes lookups are one-cycle pulses driven off the falling edge.
`timescale 1ns/10ps
`default_nettype none
module prefetch_mem (
    input wire logic clk_sys_i,
    input wire logic fetch_req_i,
    input wire logic [31:0] fetch_addr_i,
    input wire logic fc2_i,
    input wire logic fetch_hit_i,
    output logic refill_valid_o,
    output logic [31:0] refill_addr_o,
    output logic refill_fc2_o,
    output logic [31:0] refill_data_o
);
    logic req_q;
    initial {refill_valid_o, refill_addr_o, refill_fc2_o, refill_data_o} = '0;
    // Lookup taken at the rising edge
    always @(posedge clk_sys_i) req_q <= fetch_req_i;
    // Miss refilled next cycle; idle lines toggle so stale values never match
    always @(negedge clk_sys_i) begin
        refill_valid_o <= req_q && fetch_hit_i === 1'b0;
        refill_addr_o <= req_q ? fetch_addr_i : ~refill_addr_o;
        refill_fc2_o <= req_q ? fc2_i : ~refill_fc2_o;
        refill_data_o <= req_q ? {fetch_addr_i[15:0], ~fetch_addr_i[15:0]} : ~refill_data_o;
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the instruction cache control block.
// Assumes the memory model refills every miss one cycle after the lookup.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [31:0] A = 32'h1234_5678;
    localparam logic [31:0] B = 32'h0000_0104;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, sel = 1'b0, inh_n = 1'b1, req = 1'b0, fc2 = 1'b0;
    logic [31:0] wdata = '0, addr = '0, rdata, fdata, r_addr, r_data;
    logic hit, active, r_valid, r_fc2;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    // 250 MHz clock and run limit
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            stop_test();
        end
    end
    icache_control_regs u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .creg_wr_i(wr), .creg_sel_i(sel),
        .creg_wdata_i(wdata), .creg_rdata_o(rdata), .cache_inhibit_input_n_i(inh_n), .fetch_req_i(req),
        .fetch_addr_i(addr), .supervisor_space_code_bit_i(fc2), .fetch_hit_o(hit), .fetch_data_o(fdata),
        .refill_valid_i(r_valid), .refill_addr_i(r_addr), .refill_fc2_i(r_fc2), .refill_data_i(r_data),
        .cache_active_o(active));
    prefetch_mem u_mem (.clk_sys_i(clk_sys_i), .fetch_req_i(req), .fetch_addr_i(addr), .fc2_i(fc2),
        .fetch_hit_i(hit), .refill_valid_o(r_valid), .refill_addr_o(r_addr), .refill_fc2_o(r_fc2),
        .refill_data_o(r_data));
    // Comparison and bus tasks, all entered just after a falling edge
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic s, input logic [31:0] d);
        sel = s;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_sys_i) wr = 1'b0;
    endtask
    task automatic rd_reg(input logic s, input logic [31:0] exp);
        sel = s;
        @(negedge clk_sys_i) chk("register", exp, rdata);
    endtask
    task automatic fetch(input logic [31:0] a, input logic exp_hit);
        addr = a;
        req = 1'b1;
        @(negedge clk_sys_i) chk("hit", {31'h0, exp_hit}, {31'h0, hit});
        if (exp_hit) chk("data", {a[15:0], ~a[15:0]}, fdata);
        req = 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Scenarios
    task automatic t_fields();
        rd_reg(1'b0, 32'h0);
        chk("active", 32'h0, {31'h0, active});
        wr_reg(1'b0, 32'hFFFF_FFFF);
        rd_reg(1'b0, 32'h0000_0003);
        chk("active", 32'h1, {31'h0, active});
        $display("fields done");
    endtask
    task automatic t_fill();
        wr_reg(1'b0, 32'h1);
        fetch(A, 1'b0);
        fetch(A, 1'b1);
        fc2 = 1'b1;
        fetch(A, 1'b0);
        fetch(A, 1'b1);
        wr_reg(1'b0, 32'h0);
        fetch(A, 1'b0);
        wr_reg(1'b0, 32'h1);
        fetch(A, 1'b1);
        fc2 = 1'b0;
        fetch(A, 1'b0);
        fetch(A, 1'b1);
        $display("fill and enable done");
    endtask
    task automatic t_freeze_entry();
        wr_reg(1'b0, 32'h3);
        fetch(B, 1'b0);
        fetch(B, 1'b0);
        wr_reg(1'b0, 32'h1);
        fetch(B, 1'b0);
        wr_reg(1'b1, A);
        rd_reg(1'b1, A & 32'h0000_00FC);
        wr_reg(1'b0, 32'h6);
        wr_reg(1'b0, 32'h1);
        fetch(B, 1'b1);
        fetch(A, 1'b0);
        wr_reg(1'b0, 32'h9);
        fetch(B, 1'b0);
        fetch(A, 1'b0);
        $display("freeze and clears done");
    endtask
    task automatic t_inhibit_reset();
        inh_n = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk("active", 32'h0, {31'h0, active});
        fetch(A, 1'b0);
        inh_n = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        fetch(A, 1'b1);
        rst_n_i = 1'b0;
        @(negedge clk_sys_i) rst_n_i = 1'b1;
        @(negedge clk_sys_i);
        rd_reg(1'b0, 32'h0);
        wr_reg(1'b0, 32'h1);
        fetch(A, 1'b0);
        $display("inhibit and reset done");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        @(negedge clk_sys_i);
        t_fields();
        t_fill();
        t_freeze_entry();
        t_inhibit_reset();
        stop_test();
    end
endmodule
`default_nettype wire
